/* rtl/rsr_pkg.sv */
// Shared constants and types of the remote speed ramp block.
// Assumes a 10 MHz clock; frequencies are in 0.1 Hz units.
`default_nettype none
package rsr_pkg;
  // Clock and tick timing.
  localparam int unsigned CLK_NS      = 100;
  localparam int unsigned TICK_NS     = 10_000_000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int unsigned TICK_PER_S  = 1_000_000_000 / TICK_NS;
  localparam int unsigned SAVE_S      = 60;
  localparam int unsigned SAVE_TICKS  = SAVE_S * TICK_PER_S;
  // Ticks per coarse time step.
  localparam logic [7:0]  TICKS_COARSE = 8'h0a;
  // Setting value that means not used.
  localparam logic [15:0] UNUSED_SET   = 16'h270f;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_ACCEL    = 8'h04;
  localparam logic [7:0] OFS_DECEL    = 8'h08;
  localparam logic [7:0] OFS_ACCEL2   = 8'h0c;
  localparam logic [7:0] OFS_DECEL2   = 8'h10;
  localparam logic [7:0] OFS_REF      = 8'h14;
  localparam logic [7:0] OFS_SWITCH   = 8'h18;
  localparam logic [7:0] OFS_MAX      = 8'h1c;
  localparam logic [7:0] OFS_MAIN     = 8'h20;
  localparam logic [7:0] OFS_STATUS   = 8'h24;
  localparam logic [7:0] OFS_OUT_FREQ = 8'h28;
  localparam logic [7:0] OFS_REMOTE   = 8'h2c;
  localparam logic [7:0] OFS_STORED   = 8'h30;
  localparam logic [7:0] OFS_NV_COUNT = 8'h34;
  // Control field positions.
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_INC_BIT = 2;
  // Reset values and the lowest reference frequency.
  localparam logic [15:0] RST_TIME   = 16'h0032;
  localparam logic [15:0] RST_REF    = 16'h0258;
  localparam logic [15:0] RST_MAX    = 16'h04b0;
  localparam logic [15:0] RST_MAIN   = 16'h0000;
  localparam logic [15:0] MIN_REF    = 16'h000a;
  // Configuration written by software.
  typedef struct packed {
    logic [1:0]  remote_sel;
    logic        inc_sel;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] accel2;
    logic [15:0] decel2;
    logic [15:0] ref_freq;
    logic [15:0] switch_freq;
    logic [15:0] max_freq;
    logic [15:0] main_speed;
  } rsr_cfg_t;
  // Ramp engine state.
  typedef struct packed {
    logic [15:0] value;
    logic [23:0] acc;
  } rsr_ramp_st_t;
endpackage
`default_nettype wire

/* rtl/rsr_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous levels.
`default_nettype none
module rsr_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rsr_sync_st_t;

  rsr_sync_st_t s_q;
  rsr_sync_st_t s_d;

  // The first stage feeds only the second.
  always_comb begin
    s_d    = s_q;
    s_d.s1 = pin_in;
    s_d.s2 = s_q.s1;
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.s2;
endmodule
`default_nettype wire

/* rtl/rsr_ramp.sv */
// Linear ramp engine: steps a value toward a target at ref/den per tick.
// Assumes tick is a one-cycle pulse and ticks are far apart.
`default_nettype none
module rsr_ramp (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        hold,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic [15:0] target,
  input  wire logic [15:0] ref_freq,
  input  wire logic [23:0] den,
  output logic      [15:0] value
);
  rsr_pkg::rsr_ramp_st_t s_q;
  rsr_pkg::rsr_ramp_st_t s_d;
  logic [23:0]           acc_add;

  // Each tick adds ref; one step per cycle while acc covers den.
  always_comb begin
    s_d     = s_q;
    acc_add = s_q.acc + (tick ? {8'h00, ref_freq} : 24'h000000);
    if (load) begin
      s_d.value = load_val;
      s_d.acc   = '0;
    end else if (hold || s_q.value == target) begin
      s_d.acc = '0;
    end else if (den == 24'h000000) begin
      s_d.value = target; // A zero time jumps straight to the target.
      s_d.acc   = '0;
    end else if (acc_add >= den) begin
      s_d.value = (target > s_q.value) ? s_q.value + 16'h0001
                                      : s_q.value - 16'h0001; // R17
      s_d.acc   = acc_add - den;
    end else begin
      s_d.acc = acc_add;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign value = s_q.value;
endmodule
`default_nettype wire

/* rtl/rsr_top.sv */
// Remote speed setting and ramp time selection for a motor drive.
// Assumes APB master on REF_CLK; pin inputs are asynchronous levels.
// How it works
// R1: Remote frequency limited to zero..maximum, sum capped.
// R2: Select off: longer of primary or second times.
// R3: Select on: second times for remote ramps.
// R4: Up/down change preset even without start.
// R5: Host avoids storage mode under frequent changes.
// R6: Jog or process loop disables remote setting.
// R7: Power back within minute restores stored frequency.
// R8: Power back after minute starts from zero.
// R9: Acceleration time is stop to reference frequency.
// R10: Deceleration time is reference frequency to zero.
// R11: Increment selector picks 0.1 s or 0.01 s.
// R12: Select input on applies second ramp times.
// R13: Output reaching switch frequency selects second times.
// R14: Second decel 9999 reuses second accel time.
// R15: Selector 1..3 makes speed inputs up/down/clear.
// R16: Storage mode saves changed value every minute.
// R17: Output steps by reference over ramp time.
//
// Local design decisions: the APB slave port and the placing of the registers.
`default_nettype none
module rsr_top #(
  parameter int unsigned TICK_CYCLES = rsr_pkg::TICK_CYCLES,
  parameter int unsigned SAVE_TICKS  = rsr_pkg::SAVE_TICKS
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        UP_COMMAND,
  input  wire logic        DOWN_COMMAND,
  input  wire logic        CLEAR_COMMAND,
  input  wire logic        SECOND_RAMP_SELECT,
  input  wire logic        FORWARD_START,
  input  wire logic        REVERSE_START,
  input  wire logic        JOG_ACTIVE,
  input  wire logic        PROCESS_LOOP_ACTIVE,
  input  wire logic        POWER_ON,
  output logic      [15:0] OUTPUT_FREQ,
  output logic             SECOND_RAMP_ACTIVE,
  output logic             REMOTE_ACTIVE,
  output logic             NV_WRITE
);
  // Whole state of the top level.
  typedef struct packed {
    rsr_pkg::rsr_cfg_t cfg;
    logic [31:0]       prdata;
    logic              pslverr;
    logic [23:0]       tick_cnt;
    logic              tick;
    logic [23:0]       save_cnt;
    logic [15:0]       nv_freq;
    logic [15:0]       nv_count;
    logic              nv_write;
    logic              start_prev;
    logic              power_prev;
    logic              second_on;
    logic              remote_on;
  } rsr_top_st_t;

  rsr_top_st_t s_q;
  rsr_top_st_t s_d;

  // Synchronised pin levels.
  logic [8:0]  pins;
  logic        up_cmd;
  logic        down_cmd;
  logic        clear_cmd;
  logic        second_sel;
  logic        start_any;
  logic        loop_busy;
  logic        power_ok;

  // Ramp engine connections.
  logic [15:0] remote_freq;
  logic [15:0] out_freq;
  logic        remote_hold;
  logic        remote_load;
  logic [15:0] remote_load_val;
  logic [15:0] remote_target;
  logic [23:0] remote_den;
  logic        out_load;
  logic [15:0] out_target;
  logic [23:0] out_den;

  // Internal decode.
  logic        remote_en;
  logic        second_now;
  logic [15:0] decel2_eff;
  logic [15:0] up_time;
  logic [15:0] down_time;
  logic [16:0] set_sum;
  logic [16:0] set_cap;
  logic [15:0] set_freq;
  logic        start_fall;
  logic        power_rise;
  logic        released;
  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_data;
  logic [15:0] wr_half;

  // Ramp time in ticks.
  function automatic logic [23:0] ramp_den(input logic [15:0] t, input logic inc);
    logic [23:0] d;
    d = inc ? {8'h00, t} : ({8'h00, t} * {16'h0000, rsr_pkg::TICKS_COARSE});
    return d; // R11
  endfunction

  // Larger of two times.
  function automatic logic [15:0] longer(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction

  // Pin inputs pass two flip-flops before use.
  rsr_sync #(
    .W(9)
  ) u_sync (
    .clk    (REF_CLK),
    .rst    (RST),
    .pin_in ({UP_COMMAND, DOWN_COMMAND, CLEAR_COMMAND, SECOND_RAMP_SELECT,
              FORWARD_START, REVERSE_START, JOG_ACTIVE, PROCESS_LOOP_ACTIVE,
              POWER_ON}),
    .pin_out(pins)
  );

  // Name the synchronised levels.
  assign up_cmd     = pins[8];
  assign down_cmd   = pins[7];
  assign clear_cmd  = pins[6];
  assign second_sel = pins[5];
  assign start_any  = pins[4] | pins[3];
  assign loop_busy  = pins[2] | pins[1];
  assign power_ok   = pins[0];

  // Remote mode: selector set, no jog or loop.
  assign remote_en = (s_q.cfg.remote_sel != 2'b00) && !loop_busy; // R15 R6

  // Second times by select or switch frequency.
  assign second_now = second_sel || // R12
                      (s_q.cfg.switch_freq != rsr_pkg::UNUSED_SET &&
                       out_freq >= s_q.cfg.switch_freq); // R13

  // Unused second decel reuses second accel.
  assign decel2_eff = (s_q.cfg.decel2 == rsr_pkg::UNUSED_SET) ?
                      s_q.cfg.accel2 : s_q.cfg.decel2; // R14

  // Remote ramp times by select input.
  assign up_time   = second_sel ? s_q.cfg.accel2 : // R3
                     longer(s_q.cfg.accel, s_q.cfg.accel2); // R2
  assign down_time = second_sel ? decel2_eff : // R3
                     longer(s_q.cfg.decel, decel2_eff); // R2

  // Events on the start and power levels.
  assign start_fall = s_q.start_prev && !start_any;
  assign power_rise = !s_q.power_prev && power_ok;
  assign released   = !up_cmd && !down_cmd;

  // Remote ramp: up to maximum, down to zero.
  assign remote_hold   = !(remote_en && power_ok && (up_cmd ^ down_cmd)); // R4
  assign remote_target = up_cmd ? s_q.cfg.max_freq : 16'h0000; // R1
  assign remote_den    = ramp_den(up_cmd ? up_time : down_time, s_q.cfg.inc_sel);

  // Remote loads: power return, clear, mode 3 stop.
  always_comb begin
    remote_load     = 1'b0;
    remote_load_val = 16'h0000;
    if (power_rise) begin
      remote_load     = 1'b1;
      remote_load_val = (s_q.cfg.remote_sel == 2'b01) ? s_q.nv_freq : 16'h0000; // R7 R8
    end else if (remote_en && clear_cmd) begin
      remote_load = 1'b1; // R8
    end else if (s_q.cfg.remote_sel == 2'b11 && start_fall) begin
      remote_load = 1'b1;
    end
  end

  rsr_ramp u_remote (
    .clk     (REF_CLK),
    .rst     (RST),
    .tick    (s_q.tick),
    .hold    (remote_hold),
    .load    (remote_load),
    .load_val(remote_load_val),
    .target  (remote_target),
    .ref_freq(s_q.cfg.ref_freq),
    .den     (remote_den),
    .value   (remote_freq)
  );

  // Set frequency: main plus remote, capped.
  assign set_sum  = {1'b0, s_q.cfg.main_speed} + {1'b0, remote_freq};
  assign set_cap  = {1'b0, s_q.cfg.main_speed} + {1'b0, s_q.cfg.max_freq};
  always_comb begin
    if (!remote_en) begin
      set_freq = s_q.cfg.main_speed;
    end else if (set_sum > set_cap) begin
      set_freq = set_cap[16] ? 16'hffff : set_cap[15:0]; // R1
    end else begin
      set_freq = set_sum[16] ? 16'hffff : set_sum[15:0]; // R1
    end
  end

  // Output ramp times.
  assign out_target = (start_any && power_ok) ? set_freq : 16'h0000;
  assign out_load   = !power_ok;
  always_comb begin
    if (out_target > out_freq) begin
      out_den = ramp_den(second_now ? s_q.cfg.accel2 : s_q.cfg.accel, // R9
                         s_q.cfg.inc_sel);
    end else begin
      out_den = ramp_den(second_now ? decel2_eff : s_q.cfg.decel, // R10
                         s_q.cfg.inc_sel);
    end
  end

  rsr_ramp u_out (
    .clk     (REF_CLK),
    .rst     (RST),
    .tick    (s_q.tick),
    .hold    (1'b0),
    .load    (out_load),
    .load_val(16'h0000),
    .target  (out_target),
    .ref_freq(s_q.cfg.ref_freq),
    .den     (out_den),
    .value   (out_freq)
  );

  // APB: latched in setup, no wait states.
  assign setup   = PSEL && !PENABLE;
  assign wr_en   = PSEL && PENABLE && PWRITE && !s_q.pslverr;
  assign wr_half = PWDATA[15:0];
  always_comb begin
    mapped  = (PADDR[1:0] == 2'b00) && (PADDR <= rsr_pkg::OFS_NV_COUNT);
    rd_data = 32'h00000000;
    case (PADDR)
      rsr_pkg::OFS_CTRL: begin
        rd_data[rsr_pkg::CTRL_SEL_LSB +: 2] = s_q.cfg.remote_sel;
        rd_data[rsr_pkg::CTRL_INC_BIT]      = s_q.cfg.inc_sel;
      end
      rsr_pkg::OFS_ACCEL:    rd_data[15:0] = s_q.cfg.accel;
      rsr_pkg::OFS_DECEL:    rd_data[15:0] = s_q.cfg.decel;
      rsr_pkg::OFS_ACCEL2:   rd_data[15:0] = s_q.cfg.accel2;
      rsr_pkg::OFS_DECEL2:   rd_data[15:0] = s_q.cfg.decel2;
      rsr_pkg::OFS_REF:      rd_data[15:0] = s_q.cfg.ref_freq;
      rsr_pkg::OFS_SWITCH:   rd_data[15:0] = s_q.cfg.switch_freq;
      rsr_pkg::OFS_MAX:      rd_data[15:0] = s_q.cfg.max_freq;
      rsr_pkg::OFS_MAIN:     rd_data[15:0] = s_q.cfg.main_speed;
      rsr_pkg::OFS_STATUS:   rd_data[3:0]  = {power_ok, s_q.remote_on,
                                              start_any, s_q.second_on};
      rsr_pkg::OFS_OUT_FREQ: rd_data[15:0] = out_freq;
      rsr_pkg::OFS_REMOTE:   rd_data[15:0] = remote_freq;
      rsr_pkg::OFS_STORED:   rd_data[15:0] = s_q.nv_freq;
      rsr_pkg::OFS_NV_COUNT: rd_data[15:0] = s_q.nv_count;
      default:               rd_data       = 32'h00000000;
    endcase
  end

  // Next state.
  always_comb begin
    s_d          = s_q;
    s_d.nv_write = 1'b0;
    // Bus side.
    if (setup) begin
      s_d.prdata  = mapped ? rd_data : 32'h00000000;
      s_d.pslverr = !mapped;
    end
    if (wr_en) begin
      case (PADDR)
        rsr_pkg::OFS_CTRL: begin
          s_d.cfg.remote_sel = PWDATA[rsr_pkg::CTRL_SEL_LSB +: 2];
          s_d.cfg.inc_sel    = PWDATA[rsr_pkg::CTRL_INC_BIT]; // R11
        end
        rsr_pkg::OFS_ACCEL:  s_d.cfg.accel       = wr_half;
        rsr_pkg::OFS_DECEL:  s_d.cfg.decel       = wr_half;
        rsr_pkg::OFS_ACCEL2: s_d.cfg.accel2      = wr_half;
        rsr_pkg::OFS_DECEL2: s_d.cfg.decel2      = wr_half;
        rsr_pkg::OFS_REF:    s_d.cfg.ref_freq    = (wr_half < rsr_pkg::MIN_REF) ?
                                                   rsr_pkg::MIN_REF : wr_half; // R9
        rsr_pkg::OFS_SWITCH: s_d.cfg.switch_freq = wr_half;
        rsr_pkg::OFS_MAX:    s_d.cfg.max_freq    = wr_half;
        rsr_pkg::OFS_MAIN:   s_d.cfg.main_speed  = wr_half;
        default:             s_d.cfg             = s_q.cfg;
      endcase
    end
    // Control tick.
    s_d.tick = 1'b0;
    if (s_q.tick_cnt >= TICK_CYCLES[23:0] - 24'h000001) begin
      s_d.tick_cnt = '0;
      s_d.tick     = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 24'h000001;
    end
    // Storage timer and start fall.
    if (!power_ok || !released || s_q.cfg.remote_sel != 2'b01) begin
      s_d.save_cnt = '0;
    end else if (s_q.tick) begin
      if (s_q.save_cnt >= SAVE_TICKS[23:0] - 24'h000001) begin
        s_d.save_cnt = '0;
        if (remote_freq != s_q.nv_freq) begin
          s_d.nv_write = 1'b1; // R16
        end
      end else begin
        s_d.save_cnt = s_q.save_cnt + 24'h000001;
      end
    end
    if (s_q.cfg.remote_sel == 2'b01 && power_ok && start_fall &&
        remote_freq != s_q.nv_freq) begin
      s_d.nv_write = 1'b1;
    end
    if (s_d.nv_write) begin
      s_d.nv_freq  = remote_freq;
      s_d.nv_count = s_q.nv_count + 16'h0001;
    end
    // History and status.
    s_d.start_prev = start_any;
    s_d.power_prev = power_ok;
    s_d.second_on  = second_now;
    s_d.remote_on  = remote_en;
  end

  // State register.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s_q                 <= '0;
      s_q.cfg.accel       <= rsr_pkg::RST_TIME;
      s_q.cfg.decel       <= rsr_pkg::RST_TIME;
      s_q.cfg.accel2      <= rsr_pkg::RST_TIME;
      s_q.cfg.decel2      <= rsr_pkg::UNUSED_SET;
      s_q.cfg.ref_freq    <= rsr_pkg::RST_REF;
      s_q.cfg.switch_freq <= rsr_pkg::UNUSED_SET;
      s_q.cfg.max_freq    <= rsr_pkg::RST_MAX;
      s_q.cfg.main_speed  <= rsr_pkg::RST_MAIN;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs.
  assign PRDATA             = s_q.prdata;
  assign PSLVERR            = s_q.pslverr;
  assign PREADY             = PSEL && PENABLE;
  assign OUTPUT_FREQ        = out_freq;
  assign SECOND_RAMP_ACTIVE = s_q.second_on;
  assign REMOTE_ACTIVE      = s_q.remote_on;
  assign NV_WRITE           = s_q.nv_write;
endmodule
`default_nettype wire

/* test/rsr_top_monitor.sv */
// Checker of the remote speed ramp block, watching its ports only.
// Assumes it is bound to every rsr_top instance.
`default_nettype none
module rsr_top_monitor (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        SECOND_RAMP_SELECT,
  input wire logic        JOG_ACTIVE,
  input wire logic        PROCESS_LOOP_ACTIVE,
  input wire logic        POWER_ON,
  input wire logic [15:0] OUTPUT_FREQ,
  input wire logic        SECOND_RAMP_ACTIVE,
  input wire logic        REMOTE_ACTIVE,
  input wire logic        NV_WRITE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] max_q;
  logic [15:0] main_q;
  default clocking mcb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Shadow of the limit registers for the output cap.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      max_q <= rsr_pkg::RST_MAX;
      main_q <= rsr_pkg::RST_MAIN;
    end else if (PSEL && PENABLE && PWRITE && PADDR == rsr_pkg::OFS_MAX) begin
      max_q <= PWDATA[15:0];
    end else if (PSEL && PENABLE && PWRITE && PADDR == rsr_pkg::OFS_MAIN) begin
      main_q <= PWDATA[15:0];
    end
  end
  // Bus handshake and refusal.
  ready_follows_a: assert property (PREADY == (PSEL && PENABLE))
    else $error("Ready wrong.");
  bad_align_a: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0 |=>
    PSLVERR && PRDATA == 32'h0) else $error("Misaligned not refused.");
  upper_zero_a: assert property (PREADY && !PWRITE |-> PRDATA[15+1 +: 16] == 16'h0)
    else $error("Upper read bits set.");
  // Ramp behaviour.
  freq_cap_a: assert property (OUTPUT_FREQ <= {1'b0, main_q} + {1'b0, max_q})
    else $error("Output above cap.");
  freq_step_a: assert property (POWER_ON && $past(POWER_ON, 6) |->
    (OUTPUT_FREQ - $past(OUTPUT_FREQ)) inside {16'h0000, 16'h0001, 16'hffff})
    else $error("Output jumped.");
  power_off_a: assert property (!POWER_ON [*6] |-> OUTPUT_FREQ == 16'h0)
    else $error("Output on with power off.");
  remote_off_a: assert property ((JOG_ACTIVE || PROCESS_LOOP_ACTIVE) [*5] |->
    !REMOTE_ACTIVE) else $error("Remote active in jog.");
  second_sel_a: assert property (SECOND_RAMP_SELECT [*5] |-> SECOND_RAMP_ACTIVE)
    else $error("Second times unused.");
  store_pulse_a: assert property (NV_WRITE |=> !NV_WRITE)
    else $error("Store pulse too long.");
endmodule
bind rsr_top rsr_top_monitor mon (
  .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SECOND_RAMP_SELECT(SECOND_RAMP_SELECT), .JOG_ACTIVE(JOG_ACTIVE),
  .PROCESS_LOOP_ACTIVE(PROCESS_LOOP_ACTIVE), .POWER_ON(POWER_ON),
  .OUTPUT_FREQ(OUTPUT_FREQ), .SECOND_RAMP_ACTIVE(SECOND_RAMP_ACTIVE),
  .REMOTE_ACTIVE(REMOTE_ACTIVE), .NV_WRITE(NV_WRITE)
);
`default_nettype wire

/* test/rsr_host.sv */
// Host controller model driving the start and remote command pins.
// Assumes the bench updates its request word right after a rising edge.
`default_nettype none
module rsr_host (
  input  wire logic       clk,
  input  wire logic [7:0] req,
  output logic      [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins are up, down, clear, select, forward, reverse, jog, loop.
  initial pins = 8'h00;
  // Bit 5 steers start to reverse.
  always @(posedge clk) begin
    pins <= {req[7:6], req[4] & req[5], req[4] & ~req[5], req[3:0]};
  end
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench: registers, remote setting, ramp times, storage.
// Assumes rsr_pkg, the host model and the bound checker.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TC = 10;
  localparam int ST = 5;
  localparam logic [15:0] MX = 16'h003c;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pwr = 1'b1;
  logic [7:0]  req = 8'h00;
  logic [7:0]  pins;
  logic [15:0] freq;
  logic        nvw;
  logic [31:0] rd;
  logic        serr;
  logic [15:0] a, b, d, a1, a2, v;
  logic [4:0]  k;
  logic        r;
  int          n;
  int miscompares = 0;
  int samples_checked = 0;
  logic [15:0] rv [10] = '{16'h0, rsr_pkg::RST_TIME, rsr_pkg::RST_TIME, rsr_pkg::RST_TIME,
    rsr_pkg::UNUSED_SET, rsr_pkg::RST_REF, rsr_pkg::UNUSED_SET, rsr_pkg::RST_MAX,
    rsr_pkg::RST_MAIN, 16'h8};
  // Case bits: swap times, via up command, select, switch at zero, fine steps.
  logic [4:0]  cs [7] = '{5'h00, 5'h01, 5'h04, 5'h02, 5'h08, 5'h18, 5'h0c};
  always #50 clk = ~clk;
  rsr_host host (.clk(clk), .req(req), .pins(pins));
  rsr_top #(.TICK_CYCLES(TC), .SAVE_TICKS(ST)) dut (
    .REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .UP_COMMAND(pins[0]), .DOWN_COMMAND(pins[1]), .CLEAR_COMMAND(pins[2]),
    .SECOND_RAMP_SELECT(pins[3]), .FORWARD_START(pins[4]), .REVERSE_START(pins[5]),
    .JOG_ACTIVE(pins[6]), .PROCESS_LOOP_ACTIVE(pins[7]), .POWER_ON(pwr),
    .OUTPUT_FREQ(freq), .SECOND_RAMP_ACTIVE(), .REMOTE_ACTIVE(), .NV_WRITE(nvw));
  // Prints the verdict and ends the run.
  task automatic summarize();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // An exhausted wait is a mismatch.
  task automatic fail_wait();
    miscompares++;
    summarize();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Durations allow for tick phase and synchronisers.
  task automatic check_rng(input int got, input int exp);
    samples_checked++;
    if (got < exp - 3 * TC || got > exp + 3 * TC) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int m;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    m = 0;
    do begin
      @(posedge clk);
      m++;
    end while (pready !== 1'b1 && m < 50);
    rd = prdata;
    serr = pslverr;
    if (m >= 50) fail_wait();
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    check(rd, e);
  endtask
  task automatic wait_rem(input logic [15:0] t);
    int m;
    m = 0;
    do begin
      apb(1'b0, rsr_pkg::OFS_REMOTE, 32'h0);
      m++;
    end while (rd !== {16'h0, t} && m < 3000);
    if (m >= 3000) fail_wait();
  endtask
  task automatic wait_freq(input logic [15:0] t, output int m);
    m = 0;
    while (freq !== t && m < 20000) begin
      @(posedge clk);
      m++;
    end
    if (m >= 20000) fail_wait();
  endtask
  task automatic wait_nv();
    int m;
    m = 0;
    while (nvw !== 1'b1 && m < 40 * ST * TC) begin
      @(posedge clk);
      m++;
    end
    if (m >= 40 * ST * TC) fail_wait();
  endtask
  // Clears the remote value, may wait for a store, then cycles power.
  task automatic clr_pwr(input logic sv);
    req <= 8'h04;
    repeat (4) @(posedge clk);
    req <= 8'h00;
    if (sv) wait_nv();
    pwr <= 1'b0;
    repeat (8) @(posedge clk);
    pwr <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // Cycles to ramp from zero to MX.
  function automatic int exp_cyc(input logic [15:0] t, input logic inc);
    int den;
    den = inc ? int'(t) : int'(t) * 10;
    return int'(MX) * den / int'(rsr_pkg::RST_REF) * TC;
  endfunction
  // Main sequence.
  initial begin
    void'($urandom(76));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rchk(8'(4 * i), {16'h0, rv[i]});
    end
    for (int i = 1; i < 9; i++) begin
      v = 16'(10 + $urandom % 4000);
      wr(8'(4 * i), {~v, v});
      rchk(8'(4 * i), {16'h0, v});
    end
    wr(rsr_pkg::OFS_REF, 32'h3);
    rchk(rsr_pkg::OFS_REF, 32'ha);
    wr(rsr_pkg::OFS_OUT_FREQ, 32'hffff);
    rchk(rsr_pkg::OFS_OUT_FREQ, 32'h0);
    apb(1'b0, 8'h42, 32'h0);
    check({31'h0, serr}, 32'h1);
    wr(rsr_pkg::OFS_MAIN, 32'h0);
    wr(rsr_pkg::OFS_MAX, {16'h0, MX});
    wr(rsr_pkg::OFS_REF, {16'h0, rsr_pkg::RST_REF});
    wr(rsr_pkg::OFS_DECEL2, {16'h0, rsr_pkg::UNUSED_SET});
    // Ramp time cases.
    for (int c = 0; c < 7; c++) begin
      k = cs[c];
      r = 1'($urandom);
      a = 16'(10 + $urandom % 20);
      b = a + 16'h000f;
      d = 16'(10 + $urandom % 20);
      a1 = k[4] ? b : a;
      a2 = k[4] ? a : b;
      if (k[0]) begin
        a1 = a1 * 16'h000a;
        a2 = a2 * 16'h000a;
        d = d * 16'h000a;
      end
      wr(rsr_pkg::OFS_CTRL, {29'h0, k[0], 2'h2});
      wr(rsr_pkg::OFS_ACCEL, {16'h0, a1});
      wr(rsr_pkg::OFS_ACCEL2, {16'h0, a2});
      wr(rsr_pkg::OFS_DECEL, {16'h0, d});
      wr(rsr_pkg::OFS_SWITCH, {16'h0, k[1] ? 16'h0 : rsr_pkg::UNUSED_SET});
      if (k[3]) begin
        req <= {2'h0, r, 1'b0, k[2], 3'h4};
        wait_rem(16'h0);
        rchk(rsr_pkg::OFS_REMOTE, 32'h0);
        req <= {2'h0, r, 1'b1, k[2], 3'h1};
        wait_freq(MX, n);
        check_rng(n, exp_cyc(k[2] ? a2 : (a1 > a2 ? a1 : a2), k[0]));
      end else begin
        req <= {2'h0, r, 1'b0, k[2], 3'h1};
        wait_rem(MX);
        check({16'h0, freq}, 32'h0);
        req <= {2'h0, r, 1'b1, k[2], 3'h0};
        wait_freq(MX, n);
        check_rng(n, exp_cyc(k[2] | k[1] ? a2 : a1, k[0]));
      end
      req <= {2'h0, r, 1'b0, k[2], 3'h0};
      wait_freq(16'h0, n);
      if (!k[3]) check_rng(n, exp_cyc(k[2] | k[1] ? a2 : d, k[0]));
    end
    // No overshoot past end points; no remote change in jog or loop.
    req <= 8'h01;
    repeat (60 * TC) @(posedge clk);
    rchk(rsr_pkg::OFS_REMOTE, {16'h0, MX});
    req <= 8'h02;
    wait_rem(16'h0);
    repeat (20 * TC) @(posedge clk);
    rchk(rsr_pkg::OFS_REMOTE, 32'h0);
    for (int j = 6; j < 8; j++) begin
      req <= 8'h01 | (8'h01 << j);
      repeat (60 * TC) @(posedge clk);
      rchk(rsr_pkg::OFS_REMOTE, 32'h0);
    end
    v = 16'(1 + $urandom % 50);
    wr(rsr_pkg::OFS_MAIN, {16'h0, v});
    req <= 8'h01;
    wait_rem(MX);
    req <= 8'h11;
    wait_freq(v + MX, n);
    repeat (20 * TC) @(posedge clk);
    check({16'h0, freq}, {16'h0, v + MX});
    req <= 8'h00;
    wait_freq(16'h0, n);
    wr(rsr_pkg::OFS_MAIN, 32'h0);
    // Storage mode only here, where changes are rare.
    wr(rsr_pkg::OFS_CTRL, 32'h1);
    req <= 8'h01;
    wait_rem(MX);
    req <= 8'h00;
    wait_nv();
    rchk(rsr_pkg::OFS_STORED, {16'h0, MX});
    clr_pwr(1'b0);
    rchk(rsr_pkg::OFS_REMOTE, {16'h0, MX});
    clr_pwr(1'b1);
    rchk(rsr_pkg::OFS_REMOTE, 32'h0);
    repeat (3 * ST * TC) @(posedge clk);
    rchk(rsr_pkg::OFS_NV_COUNT, 32'h2);
    // Mode 3: start falling clears the remote value.
    wr(rsr_pkg::OFS_CTRL, 32'h3);
    req <= 8'h11;
    wait_rem(MX);
    req <= 8'h00;
    repeat (8) @(posedge clk);
    rchk(rsr_pkg::OFS_REMOTE, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
